// *** trig_ctrl_defines.svh ***
// Constants of the timer clock and trigger controller: field codes,
// encodings, reset values and resynchroniser depth.
// Assumes inclusion by bare name; definitions only.
`ifndef TRIG_CTRL_DEFINES_SVH
`define TRIG_CTRL_DEFINES_SVH

// ---------------------------------------------------------------------
// Slave mode select codes
// ---------------------------------------------------------------------
`define SMS_DISABLED     3'h0
`define SMS_RESET        3'h4
`define SMS_GATED        3'h5
`define SMS_TRIGGER      3'h6
`define SMS_EXT_CLOCK1   3'h7

// ---------------------------------------------------------------------
// Trigger source select codes
// ---------------------------------------------------------------------
`define TS_INTERNAL0     3'h0
`define TS_INTERNAL1     3'h1
`define TS_INTERNAL2     3'h2
`define TS_INTERNAL3     3'h3
`define TS_EXT_PIN       3'h7
`define TS_INPUT_ONE     3'h5
`define TS_INPUT_TWO     3'h6

// ---------------------------------------------------------------------
// Filter, prescaler, resynchroniser depth and reset values
// ---------------------------------------------------------------------
`define FILTER_NONE      4'h0
`define EXT_TRIG_PRESCALE_DIV1        2'h0
`define SYNC_STAGES      2
`define COUNT_RESET      16'h0000

`endif

// *** trig_ctrl_pkg.sv ***
// Types shared by the clock and trigger controller files.
// Assumes the defines header is compiled alongside.
package trig_ctrl_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_RUN   = 4'b0010,
      ST_GATED = 4'b0100,
      ST_EXTCK = 4'b1000
   } run_state_type;
endpackage

// *** input_conditioner.sv ***
// Resynchroniser, digital filter and edge detector for one trigger input.
// Assumes the input is a level from a pin; all logic on CLK.
`timescale 1ns/1ps
`default_nettype none
`include "trig_ctrl_defines.svh"
module input_conditioner (
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RSTN,
   // Input and settings
   input  wire logic       PIN,
   input  wire logic [3:0] FILTER,
   input  wire logic       POLARITY,
   // Conditioned outputs
   output logic            LEVEL,
   output logic            RISE,
   output logic            FALL
);
   logic       sync1_r;
   logic       sync2_r;
   logic       filt_r;
   logic       filt_d_r;
   logic [4:0] run_r;
   logic [4:0] run_nxt;
   logic       agree;
   logic       filt_nxt;

   // -------------------------------------------------------------------
   // Resynchroniser, first stage feeds only the second
   // -------------------------------------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= PIN;
         sync2_r <= sync1_r;
      end
   end

   // Filter needs FILTER+1 stable samples; zero passes straight through
   assign agree    = (sync2_r != filt_r);
   assign run_nxt  = agree ? (run_r + 5'h01) : 5'h00;
   assign filt_nxt = (FILTER == `FILTER_NONE) ? sync2_r :
                     (agree && run_r >= {1'b0, FILTER}) ? sync2_r : filt_r;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         run_r    <= 5'h00;
         filt_r   <= 1'b0;
         filt_d_r <= 1'b0;
      end else begin
         run_r    <= (filt_nxt != filt_r) ? 5'h00 : run_nxt;
         filt_r   <= filt_nxt;
         filt_d_r <= filt_r;
      end
   end

   // Polarity 1 swaps edges and inverts level
   assign LEVEL = filt_r ^ POLARITY;
   assign RISE  = POLARITY ? (filt_d_r & ~filt_r) : (~filt_d_r & filt_r);
   assign FALL  = POLARITY ? (~filt_d_r & filt_r) : (filt_d_r & ~filt_r);
endmodule
`default_nettype wire

// *** ext_trig_divider.sv ***
// Edge divider of the external trigger path: one pulse per 1, 2, 4 or 8
// active edges. Assumes edges arrive as one-cycle pulses on CLK.
`timescale 1ns/1ps
`default_nettype none
`include "trig_ctrl_defines.svh"
module ext_trig_divider (
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RSTN,
   // Edge in, ratio, pulse out
   input  wire logic       EDGE,
   input  wire logic [1:0] PRESCALE,
   output logic            PULSE
);
   logic [2:0] cnt_r;
   logic [2:0] limit;
   logic       wrap;

   // Limit is ratio minus one
   assign limit = 3'((4'h1 << PRESCALE) - 4'h1);
   assign wrap  = EDGE && (cnt_r >= limit);

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cnt_r <= 3'h0;
         PULSE <= 1'b0;
      end else begin
         PULSE <= wrap;
         if (wrap) begin
            cnt_r <= 3'h0;
         end else if (EDGE) begin
            cnt_r <= cnt_r + 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

// *** timer_clock_trigger_ctrl.sv ***
// Clock and trigger controller of a 16-bit timer with a small up-counter.
// Assumes all inputs synchronous or resynchronised here; one clock.
// Operation
// - Prescaler clock from four selectable sources
// - Mode 000, no clock2: software-only controls
// - Internal clock starts once run set
// - Mode 111 counts each trigger edge
// - Select 110 input two, 101 input one
// - Clock mode 1 edge sets trigger flag
// - Polarity 0 rising/high, 1 falling/low
// - Input filter 0000 means no filtering
// - Capture settings never touch trigger path
// - Clock2 enable counts external pin edges
// - External prescale divides by 1,2,4,8
// - External polarity 0 selects rising edge
// - External filter 0000 means no filtering
// - Pins pass through resynchronisers first
// - Seven trigger sources: pin, inputs, companions
// - Mode 110 trigger edge starts counter
// - Mode 100 trigger reinitialises counter, prescaler
// - Reset mode, source low: update event
// - Reset mode restarts at zero, sets flag
// - Mode 101 counts while level active
// - Gated mode never counts without run
// - Clock2 combines with other trigger source
// - Update generate restarts counter and prescaler
// - Source bit set: no update flag
`timescale 1ns/1ps
`default_nettype none
`include "trig_ctrl_defines.svh"
module timer_clock_trigger_ctrl (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RSTN,
   // Pins and companion triggers
   input  wire logic        TIMER_INPUT_ONE,
   input  wire logic        TIMER_INPUT_TWO,
   input  wire logic        EXT_TRIGGER_PIN,
   input  wire logic [3:0]  INTERNAL_TRIGGER_IN,
   // Slave mode configuration
   input  wire logic [2:0]  SLAVE_MODE_SELECT,
   input  wire logic [2:0]  TRIGGER_SOURCE_SELECT,
   input  wire logic        EXT_CLOCK2_ENABLE,
   // Input channel configuration
   input  wire logic        INPUT_ONE_POLARITY,
   input  wire logic        INPUT_TWO_POLARITY,
   input  wire logic [3:0]  INPUT_ONE_FILTER,
   input  wire logic [3:0]  INPUT_TWO_FILTER,
   input  wire logic [1:0]  CAPTURE_ONE_SOURCE_SEL,
   input  wire logic [1:0]  CAPTURE_TWO_SOURCE_SEL,
   // External trigger configuration
   input  wire logic [3:0]  EXT_TRIG_FILTER,
   input  wire logic [1:0]  EXT_TRIG_PRESCALE,
   input  wire logic        EXT_TRIG_POLARITY,
   // Software control strobes and bits
   input  wire logic        RUN_SET,
   input  wire logic        RUN_CLEAR,
   input  wire logic        UPDATE_GENERATE_BIT,
   input  wire logic        UPDATE_REQUEST_SOURCE,
   input  wire logic        TRIGGER_IRQ_ENABLE,
   input  wire logic        TRIGGER_FLAG_CLEAR,
   input  wire logic        UPDATE_FLAG_CLEAR,
   // Status and outputs
   output logic             COUNTER_RUN_BIT,
   output logic             TRIGGER_FLAG,
   output logic             UPDATE_FLAG,
   output logic             TRIGGER_IRQ,
   output logic             UPDATE_EVENT,
   output logic             PRESCALER_CLOCK,
   output logic             PRESCALER_RESTART,
   output logic             SELECTED_TRIGGER_IN,
   output logic [15:0]      COUNTER
);
   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   logic       in1_level;
   logic       in1_rise;
   logic       in1_fall;
   logic       in2_level;
   logic       in2_rise;
   logic       in2_fall;
   logic       etr_level;
   logic       etr_rise;
   logic       etr_fall;
   logic       etr_pulse;
   logic [3:0] itr_s1_r;
   logic [3:0] itr_s2_r;
   logic [3:0] itr_d_r;
   logic       trg_level;
   logic       trg_edge;
   logic       trg_any;
   logic       gate_prev_r;
   logic       run_r;
   logic       run_nxt;
   logic       tflag_r;
   logic       uflag_r;
   logic       ug_d_r;
   logic       ug_pulse;
   logic       reset_trig;
   logic       restart;
   logic       tick;
   logic       gate_on;
   logic       gate_changed;
   logic       trig_event;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic       ck_r;
   trig_ctrl_pkg::run_state_type state;

   // Active level and edge selection of one source
   function automatic logic pick(input logic [2:0] sel,
                                 input logic a1, input logic a2,
                                 input logic ae, input logic [3:0] ai);
      case (sel)
         `TS_INPUT_ONE: pick = a1;
         `TS_INPUT_TWO: pick = a2;
         `TS_EXT_PIN:   pick = ae;
         `TS_INTERNAL0: pick = ai[0];
         `TS_INTERNAL1: pick = ai[1];
         `TS_INTERNAL2: pick = ai[2];
         `TS_INTERNAL3: pick = ai[3];
         default:       pick = 1'b0;
      endcase
   endfunction

   // -------------------------------------------------------------------
   // Input conditioning
   // -------------------------------------------------------------------
   // Capture source selects are deliberately unused here
   input_conditioner u_in1 (
      .CLK      (CLK),
      .RSTN     (RSTN),
      .PIN      (TIMER_INPUT_ONE),
      .FILTER   (INPUT_ONE_FILTER),
      .POLARITY (INPUT_ONE_POLARITY),
      .LEVEL    (in1_level),
      .RISE     (in1_rise),
      .FALL     (in1_fall)
   );

   input_conditioner u_in2 (
      .CLK      (CLK),
      .RSTN     (RSTN),
      .PIN      (TIMER_INPUT_TWO),
      .FILTER   (INPUT_TWO_FILTER),
      .POLARITY (INPUT_TWO_POLARITY),
      .LEVEL    (in2_level),
      .RISE     (in2_rise),
      .FALL     (in2_fall)
   );

   input_conditioner u_etr (
      .CLK      (CLK),
      .RSTN     (RSTN),
      .PIN      (EXT_TRIGGER_PIN),
      .FILTER   (EXT_TRIG_FILTER),
      .POLARITY (EXT_TRIG_POLARITY),
      .LEVEL    (etr_level),
      .RISE     (etr_rise),
      .FALL     (etr_fall)
   );

   // Divided external edges feed clock mode 2
   ext_trig_divider u_div (
      .CLK      (CLK),
      .RSTN     (RSTN),
      .EDGE     (etr_rise),
      .PRESCALE (EXT_TRIG_PRESCALE),
      .PULSE    (etr_pulse)
   );

   // Companion triggers resynchronised, then delayed for edges
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         itr_s1_r <= 4'h0;
         itr_s2_r <= 4'h0;
         itr_d_r  <= 4'h0;
      end else begin
         itr_s1_r <= INTERNAL_TRIGGER_IN;
         itr_s2_r <= itr_s1_r;
         itr_d_r  <= itr_s2_r;
      end
   end

   // -------------------------------------------------------------------
   // Trigger selection
   // -------------------------------------------------------------------
   // Companions trigger on rising edges only
   assign trg_level = pick(TRIGGER_SOURCE_SELECT, in1_level, in2_level,
                           etr_level, itr_s2_r);
   assign trg_edge  = pick(TRIGGER_SOURCE_SELECT, in1_rise, in2_rise,
                           etr_rise, itr_s2_r & ~itr_d_r);
   // Fall outputs left unused: polarity already folded into rise
   assign trg_any   = in1_fall | in2_fall | etr_fall;
   assign SELECTED_TRIGGER_IN = trg_level;

   // -------------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------------
   assign ug_pulse     = UPDATE_GENERATE_BIT & ~ug_d_r;
   assign reset_trig   = (SLAVE_MODE_SELECT == `SMS_RESET) & trg_edge;
   assign restart      = ug_pulse | reset_trig;
   assign gate_on      = (SLAVE_MODE_SELECT == `SMS_GATED) & trg_level;
   assign gate_changed = (SLAVE_MODE_SELECT == `SMS_GATED)
                         & run_r & (trg_level != gate_prev_r);
   assign trig_event   = gate_changed
                         | (trg_edge & (SLAVE_MODE_SELECT == `SMS_RESET
                         | SLAVE_MODE_SELECT == `SMS_TRIGGER
                         | SLAVE_MODE_SELECT == `SMS_EXT_CLOCK1));

   // Run bit: software only in mode 000, trigger mode may set it
   assign run_nxt = RUN_SET ? 1'b1 :
                    RUN_CLEAR ? 1'b0 :
                    ((SLAVE_MODE_SELECT == `SMS_TRIGGER) & trg_edge)
                    ? 1'b1 : run_r;

   // Clock source, external clock 2 has priority over master clock
   always_comb begin
      if (!run_r) begin
         state = trig_ctrl_pkg::ST_IDLE;
      end else if (SLAVE_MODE_SELECT == `SMS_EXT_CLOCK1) begin
         state = trig_ctrl_pkg::ST_EXTCK;
      end else if (SLAVE_MODE_SELECT == `SMS_GATED) begin
         state = trig_ctrl_pkg::ST_GATED;
      end else begin
         state = trig_ctrl_pkg::ST_RUN;
      end
   end

   // Gated mode still obeys clock 2 and needs run set
   always_comb begin
      case (state)
         trig_ctrl_pkg::ST_IDLE:  tick = 1'b0;
         trig_ctrl_pkg::ST_EXTCK: tick = trg_edge;
         trig_ctrl_pkg::ST_GATED:
            tick = gate_on & (EXT_CLOCK2_ENABLE ? etr_pulse : 1'b1);
         trig_ctrl_pkg::ST_RUN:
            tick = EXT_CLOCK2_ENABLE ? etr_pulse : 1'b1;
         default: tick = 1'b0;
      endcase
   end
   // Selecting the pin as trigger with clock 2 is left to software

   assign cnt_nxt = restart ? `COUNT_RESET :
                    tick ? cnt_r + 16'h0001 : cnt_r;

   // -------------------------------------------------------------------
   // State registers
   // -------------------------------------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         run_r       <= 1'b0;
         cnt_r       <= `COUNT_RESET;
         ug_d_r      <= 1'b0;
         gate_prev_r <= 1'b0;
         ck_r        <= 1'b0;
      end else begin
         run_r       <= run_nxt;
         cnt_r       <= cnt_nxt;
         ug_d_r      <= UPDATE_GENERATE_BIT;
         gate_prev_r <= trg_level;
         ck_r        <= tick;
      end
   end

   // Sticky flags; a new event wins over a clear in the same cycle
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         tflag_r      <= 1'b0;
         uflag_r      <= 1'b0;
         UPDATE_EVENT <= 1'b0;
         PRESCALER_RESTART <= 1'b0;
      end else begin
         tflag_r <= trig_event | (tflag_r & ~TRIGGER_FLAG_CLEAR);
         // Update request source set hides software and trigger updates
         uflag_r <= (restart & ~UPDATE_REQUEST_SOURCE)
                    | (uflag_r & ~UPDATE_FLAG_CLEAR);
         UPDATE_EVENT <= ug_pulse
                         | (reset_trig & ~UPDATE_REQUEST_SOURCE);
         PRESCALER_RESTART <= restart;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign COUNTER_RUN_BIT = run_r;
   assign TRIGGER_FLAG    = tflag_r;
   assign UPDATE_FLAG     = uflag_r;
   assign TRIGGER_IRQ     = tflag_r & TRIGGER_IRQ_ENABLE;
   assign PRESCALER_CLOCK = ck_r;
   assign COUNTER         = cnt_r;

   // Unused capture fields and fall edges kept visible for review
   logic unused_ok;
   assign unused_ok = ^{CAPTURE_ONE_SOURCE_SEL, CAPTURE_TWO_SOURCE_SEL,
                        trg_any};
endmodule
`default_nettype wire

// *** timer_clock_trigger_ctrl_asserts.sv ***
// Concurrent checks on the ports of the clock and trigger controller.
// Assumes binding to the top module; single clock CLK, reset RSTN.
`timescale 1ns/1ps
`default_nettype none
`include "trig_ctrl_defines.svh"
module timer_clock_trigger_ctrl_checker (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RSTN,
   // Watched inputs
   input  wire logic [2:0]  SLAVE_MODE_SELECT,
   input  wire logic        EXT_CLOCK2_ENABLE,
   input  wire logic        RUN_SET,
   input  wire logic        RUN_CLEAR,
   input  wire logic        UPDATE_GENERATE_BIT,
   input  wire logic        UPDATE_REQUEST_SOURCE,
   input  wire logic        TRIGGER_IRQ_ENABLE,
   input  wire logic        TRIGGER_FLAG_CLEAR,
   // Watched outputs
   input  wire logic        COUNTER_RUN_BIT,
   input  wire logic        TRIGGER_FLAG,
   input  wire logic        UPDATE_FLAG,
   input  wire logic        TRIGGER_IRQ,
   input  wire logic        UPDATE_EVENT,
   input  wire logic        PRESCALER_CLOCK,
   input  wire logic        PRESCALER_RESTART,
   input  wire logic [15:0] COUNTER
);
   // ----------------------------------------------------------------
   // Properties, all on CLK and quiet during reset
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   a_irq_follows_flag: assert property (
      TRIGGER_IRQ == (TRIGGER_FLAG && TRIGGER_IRQ_ENABLE))
      else $error("trigger irq differs from flag and enable");
   a_flag_stays_set: assert property (
      TRIGGER_FLAG && !TRIGGER_FLAG_CLEAR |=> TRIGGER_FLAG)
      else $error("trigger flag dropped without a clear");
   a_run_set_lands: assert property (
      RUN_SET |=> COUNTER_RUN_BIT)
      else $error("run bit not set after run write");
   a_run_sw_only: assert property (
      SLAVE_MODE_SELECT == `SMS_DISABLED && !EXT_CLOCK2_ENABLE
      && !RUN_SET && !RUN_CLEAR |=> $stable(COUNTER_RUN_BIT))
      else $error("run bit moved without a write");
   // Margin of two cycles for the registered count pulse to drain
   a_gated_needs_run: assert property (
      (SLAVE_MODE_SELECT == `SMS_GATED && !COUNTER_RUN_BIT
      && !EXT_CLOCK2_ENABLE)[*3] |-> $stable(COUNTER))
      else $error("gated counter moved with run low");
   a_count_step: assert property (
      PRESCALER_CLOCK && !PRESCALER_RESTART
      |-> COUNTER == $past(COUNTER) + 16'h0001)
      else $error("count pulse did not add one");
   a_ug_update: assert property (
      $rose(UPDATE_GENERATE_BIT) |-> ##[1:2] UPDATE_EVENT)
      else $error("no update event after update generate");
   a_ug_restart: assert property (
      $rose(UPDATE_GENERATE_BIT) |-> ##[1:3] COUNTER == `COUNT_RESET)
      else $error("counter not restarted by update generate");
   a_urs_quiet: assert property (
      $rose(UPDATE_GENERATE_BIT) && UPDATE_REQUEST_SOURCE && !UPDATE_FLAG
      |=> !UPDATE_FLAG [*2])
      else $error("update flag set with source bit high");
endmodule
`default_nettype wire

// *** trig_source_model.sv ***
// Far-side model: timer input pins, external trigger pin and the
// companion timers' trigger outputs. Assumes driving on falling edges.
`timescale 1ns/1ps
`default_nettype none
module trig_source_model (
   // Clock
   input  wire logic       clk,
   // Levels presented to the timer
   output logic            ti_one,
   output logic            ti_two,
   output logic            etr_pin,
   output logic [3:0]      itr
);
   // Bits 0-3 companions, 4 input one, 5 input two, 6 external pin
   logic [6:0] lv = 7'h00;
   assign {etr_pin, ti_two, ti_one, itr} = lv;

   // Levels change just after a falling edge, clear of sampling
   task automatic set_pin(input int s, input logic v);
      @(negedge clk);
      lv[s] = v;
   endtask

   // Three cycles high and low, so an unfiltered path sees each edge
   task automatic pulses(input int s, input int n);
      repeat (n) begin
         set_pin(s, 1'b1);
         repeat (2) @(negedge clk);
         set_pin(s, 1'b0);
         repeat (2) @(negedge clk);
      end
   endtask
endmodule
`default_nettype wire

// *** timer_clock_trigger_ctrl_tb.sv ***
// Self-checking bench for the clock and trigger controller.
// Assumes the design, the source model and the checker are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "trig_ctrl_defines.svh"
module timer_clock_trigger_ctrl_tb;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic        clk = 1'b0, rstn = 1'b0;
   wire  logic  ti1, ti2, ext_trigger_pin;
   wire  logic [3:0] itr;
   logic [2:0]  slave_mode_select = 3'h0, ts = 3'h4;
   logic        ece = 1'b0, pol1 = 1'b0, pol2 = 1'b0, ext_trig_polarity = 1'b0;
   logic [1:0]  cs1 = 2'h0, cs2 = 2'h0, ext_trig_prescale = 2'h0;
   logic        update_request_source = 1'b1, trigger_irq_enable = 1'b0;
   logic [4:0]  strb = 5'h00;
   logic        run, tflag, uflag, tirq, update_event, pclk, prst, selected_trigger_in;
   logic [15:0] cnt;
   int          n_errors = 0, samples_checked = 0, cycles = 0;

   always #2.5 clk = ~clk;

   trig_source_model src (.clk(clk), .ti_one(ti1), .ti_two(ti2),
      .etr_pin(ext_trigger_pin), .itr(itr));

   // Filters stay at zero: every pulse is at least three cycles wide
   timer_clock_trigger_ctrl uut (.CLK(clk), .RSTN(rstn),
      .TIMER_INPUT_ONE(ti1), .TIMER_INPUT_TWO(ti2),
      .EXT_TRIGGER_PIN(ext_trigger_pin), .INTERNAL_TRIGGER_IN(itr),
      .SLAVE_MODE_SELECT(slave_mode_select), .TRIGGER_SOURCE_SELECT(ts),
      .EXT_CLOCK2_ENABLE(ece), .INPUT_ONE_POLARITY(pol1),
      .INPUT_TWO_POLARITY(pol2), .INPUT_ONE_FILTER(4'h0),
      .INPUT_TWO_FILTER(4'h0), .CAPTURE_ONE_SOURCE_SEL(cs1),
      .CAPTURE_TWO_SOURCE_SEL(cs2), .EXT_TRIG_FILTER(4'h0),
      .EXT_TRIG_PRESCALE(ext_trig_prescale), .EXT_TRIG_POLARITY(ext_trig_polarity),
      .RUN_SET(strb[0]), .RUN_CLEAR(strb[1]),
      .UPDATE_GENERATE_BIT(strb[2]), .UPDATE_REQUEST_SOURCE(update_request_source),
      .TRIGGER_IRQ_ENABLE(trigger_irq_enable), .TRIGGER_FLAG_CLEAR(strb[3]),
      .UPDATE_FLAG_CLEAR(strb[4]), .COUNTER_RUN_BIT(run),
      .TRIGGER_FLAG(tflag), .UPDATE_FLAG(uflag), .TRIGGER_IRQ(tirq),
      .UPDATE_EVENT(update_event), .PRESCALER_CLOCK(pclk),
      .PRESCALER_RESTART(prst), .SELECTED_TRIGGER_IN(selected_trigger_in),
      .COUNTER(cnt));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask

   // 0 run set, 1 run clear, 2 update generate, 3/4 flag clears
   task automatic strobe(input int k);
      @(negedge clk);
      strb[k] = 1'b1;
      @(negedge clk);
      strb[k] = 1'b0;
   endtask

   // Hang guard, well above the roughly 840 cycles of the run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_internal;
      logic [15:0] c0;
      strobe(0);
      wait_n(2);
      c0 = cnt;
      wait_n(10);
      check("internal count", cnt - c0, 16'h000a);
      strobe(1);
      wait_n(2);
      c0 = cnt;
      wait_n(5);
      check("stopped count", cnt, c0);
      strobe(2);
      wait_n(3);
      check("update restart", cnt, `COUNT_RESET);
      check("quiet update", {15'h0, uflag}, 16'h0000);
      update_request_source = 1'b0;
      strobe(2);
      wait_n(3);
      check("update flag", {15'h0, uflag}, 16'h0001);
      strobe(4);
   endtask

   // Level step first, so the polarity decides which edge counts
   task automatic t_clock1(input logic [2:0] sel, input int s,
                           input logic pol);
      logic [15:0] c0;
      slave_mode_select = `SMS_EXT_CLOCK1;
      ts = sel;
      pol1 = pol;
      pol2 = pol;
      cs1 = 2'h3;
      cs2 = 2'h2;
      trigger_irq_enable = 1'b1;
      wait_n(8);
      strobe(3);
      c0 = cnt;
      src.set_pin(s, 1'b1);
      wait_n(8);
      check("step edge", cnt - c0, {15'h0, !pol});
      src.set_pin(s, 1'b0);
      wait_n(8);
      check("edge pair", cnt - c0, 16'h0001);
      check("irq", {15'h0, tirq}, 16'h0001);
      src.pulses(s, 3);
      wait_n(8);
      check("pulse count", cnt - c0, 16'h0004);
   endtask

   task automatic t_clock2;
      logic [15:0] c0;
      slave_mode_select = `SMS_DISABLED;
      ts = 3'h4;
      ece = 1'b1;
      for (int p = 0; p < 4; p++) begin
         ext_trig_prescale = p[1:0];
         wait_n(4);
         c0 = cnt;
         src.pulses(6, 8);
         wait_n(8);
         check("ext divide", cnt - c0, 16'h0008 >> p);
      end
      ext_trig_prescale = 2'h0;
   endtask

   // Trigger start combined with counting on the external pin
   task automatic t_trigger;
      logic [15:0] c0;
      strobe(1);
      slave_mode_select = `SMS_TRIGGER;
      ts = `TS_INPUT_ONE;
      pol1 = 1'b0;
      wait_n(8);
      strobe(3);
      c0 = cnt;
      src.pulses(6, 2);
      wait_n(8);
      check("idle ext", cnt - c0, 16'h0000);
      src.pulses(4, 1);
      wait_n(8);
      check("started", {14'h0, run, tflag}, 16'h0003);
      src.pulses(6, 4);
      wait_n(8);
      check("ext counts", cnt - c0, 16'h0004);
      ece = 1'b0;
   endtask

   task automatic t_reset_mode;
      slave_mode_select = `SMS_RESET;
      update_request_source = 1'b0;
      wait_n(20);
      strobe(3);
      strobe(4);
      src.pulses(4, 1);
      check("restart low", {15'h0, cnt < 16'h0008}, 16'h0001);
      check("flags", {14'h0, tflag, uflag}, 16'h0003);
   endtask

   // Active-low gate; run low must hold the counter whatever the level
   task automatic t_gated;
      logic [15:0] c0;
      strobe(1);
      slave_mode_select = `SMS_GATED;
      pol1 = 1'b1;
      wait_n(8);
      c0 = cnt;
      wait_n(6);
      check("no run", cnt - c0, 16'h0000);
      src.set_pin(4, 1'b1);
      strobe(0);
      wait_n(8);
      strobe(3);
      c0 = cnt;
      wait_n(5);
      check("gate shut", {15'h0, selected_trigger_in}, 16'h0000);
      check("shut count", cnt - c0, 16'h0000);
      src.set_pin(4, 1'b0);
      wait_n(8);
      check("gate open", {14'h0, tflag, cnt != c0}, 16'h0003);
      strobe(3);
      src.set_pin(4, 1'b1);
      wait_n(8);
      c0 = cnt;
      wait_n(5);
      check("gate stop", {tflag, 15'(cnt - c0)}, 16'h8000);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      wait_n(12);
      rstn = 1'b1;
      wait_n(2);
      t_internal();
      $display("Test internal clock done");
      strobe(0);
      t_clock1(`TS_INPUT_TWO, 5, 1'b0);
      t_clock1(`TS_INPUT_ONE, 4, 1'b1);
      for (int i = 0; i < 4; i++) begin
         t_clock1(i[2:0], i, 1'b0);
      end
      t_clock1(`TS_EXT_PIN, 6, 1'b0);
      $display("Test external clock one done");
      t_clock2();
      $display("Test external clock two done");
      t_trigger();
      $display("Test trigger mode done");
      t_reset_mode();
      $display("Test reset mode done");
      t_gated();
      $display("Test gated mode done");
      report_and_stop();
   end
endmodule

bind timer_clock_trigger_ctrl timer_clock_trigger_ctrl_checker chk (
   .CLK(CLK), .RSTN(RSTN), .SLAVE_MODE_SELECT(SLAVE_MODE_SELECT),
   .EXT_CLOCK2_ENABLE(EXT_CLOCK2_ENABLE), .RUN_SET(RUN_SET),
   .RUN_CLEAR(RUN_CLEAR), .UPDATE_GENERATE_BIT(UPDATE_GENERATE_BIT),
   .UPDATE_REQUEST_SOURCE(UPDATE_REQUEST_SOURCE),
   .TRIGGER_IRQ_ENABLE(TRIGGER_IRQ_ENABLE),
   .TRIGGER_FLAG_CLEAR(TRIGGER_FLAG_CLEAR),
   .COUNTER_RUN_BIT(COUNTER_RUN_BIT), .TRIGGER_FLAG(TRIGGER_FLAG),
   .UPDATE_FLAG(UPDATE_FLAG), .TRIGGER_IRQ(TRIGGER_IRQ),
   .UPDATE_EVENT(UPDATE_EVENT), .PRESCALER_CLOCK(PRESCALER_CLOCK),
   .PRESCALER_RESTART(PRESCALER_RESTART), .COUNTER(COUNTER));
`default_nettype wire
